// File: verilog/pwr_mode_pkg.sv
// Constants and types shared by the power mode and wake-up controller
package pwr_mode_pkg;
  // ==========================================
  // Register map
  localparam int         DATA_W     = 8;
  localparam int         ADDR_W     = 2;
  localparam int         PORTA_W    = 8;
  localparam logic [1:0] ADDR_SCC   = 2'h0;
  localparam logic [1:0] ADDR_HOSC  = 2'h1;
  localparam logic [1:0] ADDR_WAKE  = 2'h2;
  localparam logic [1:0] ADDR_STAT  = 2'h3;
  // ==========================================
  // Field positions
  localparam int SEL_MSB       = 7;
  localparam int SEL_LSB       = 5;
  localparam int HS_KEEP_BIT   = 1;
  localparam int LS_KEEP_BIT   = 0;
  localparam int HS_STABLE_BIT = 1;
  localparam int HS_EN_BIT     = 0;
  localparam int STAT_PDF_BIT  = 0;
  localparam int STAT_TO_BIT   = 1;
  localparam int STAT_MODE_LSB = 2;
  // ==========================================
  // Reset values and codes
  localparam logic [7:0] SCC_RST   = 8'h00;
  localparam logic       HS_EN_RST = 1'b1;
  localparam logic [7:0] WAKE_RST  = 8'h00;
  localparam logic [2:0] SEL_SUB   = 3'h7;
  // ==========================================
  // Timing
  localparam int MCLK_HZ  = 50_000_000;
  localparam int LS_RC_OSCILLATOR_HZ  = 32_000;
  localparam int LS_RC_OSCILLATOR_DIV = MCLK_HZ / LS_RC_OSCILLATOR_HZ;
  // ==========================================
  // Operating modes
  typedef enum logic [2:0] {
    MODE_FAST              = 3'b000,
    MODE_SLOW              = 3'b001,
    MODE_SLEEP             = 3'b010,
    MODE_IDLE_LOWCLK_ONLY  = 3'b011,
    MODE_IDLE_BOTH_CLOCKS  = 3'b100,
    MODE_IDLE_HIGHCLK_ONLY = 3'b101,
    MODE_WAKE              = 3'b110
  } mode_t;
endpackage : pwr_mode_pkg

// File: verilog/power_mode_wakeup_control.sv
// Operating mode, system clock selection and wake-up control
//
// What this block does
// RULE_01: Select code 111 in FAST moves to SLOW
// RULE_02: Codes 000-110 in SLOW return to FAST
// RULE_03: Enter SLOW only once sub oscillator stable
// RULE_04: Restart high clock, wait stable flag first
// RULE_05: Halt with keep 00 enters SLEEP
// RULE_06: Halt with keep 01 keeps sub only
// RULE_07: Halt with keep 11 keeps both clocks
// RULE_08: Halt with keep 10 keeps high only
// RULE_09: Low power stops execution, holds state
// RULE_10: Halt sets power-down, clears timeout flag
// RULE_11: Low power entry clears watchdog counter
// RULE_12: Port A edge, interrupt or overflow wakes
// RULE_13: Power-up or watchdog clear clears power-down
// RULE_14: Overflow in low power sets timeout, wakes
// RULE_15: Per-pin wake enable, resume after halt
// RULE_16: Unserviceable interrupt wake resumes, stays pending
// RULE_17: Serviceable interrupt wake vectors normally
// RULE_18: Already pending interrupt cannot wake
// RULE_19: Resume only after oscillator restarts stable
// RULE_20: Select codes divide high clock 1 to 64
// RULE_21: Oscillator enable clears then sets stable flag
// RULE_22: SLEEP keeps slow RC only with watchdog
// RULE_23: Clock source switches without glitches
// RULE_24: Keep bits sampled at halt
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module power_mode_wakeup_control #(
  parameter int IRQ_W    = 8,
  parameter int LS_RC_OSCILLATOR_CYC = pwr_mode_pkg::LS_RC_OSCILLATOR_DIV
) (
  input  wire logic                              mclk_i,
  input  wire logic                              rst_b_i,
  input  wire logic [pwr_mode_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [pwr_mode_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                              wr_i,
  input  wire logic                              rd_i,
  output logic      [pwr_mode_pkg::DATA_W-1:0]   rdata_o,
  input  wire logic                              halt_i,
  input  wire logic                              clr_wdt_i,
  input  wire logic                              wdt_enable_i,
  input  wire logic                              wdt_overflow_i,
  input  wire logic [IRQ_W-1:0]                  irq_req_i,
  input  wire logic [IRQ_W-1:0]                  irq_en_i,
  input  wire logic                              stack_full_i,
  input  wire logic [pwr_mode_pkg::PORTA_W-1:0]  porta_i,
  input  wire logic                              hs_ready_i,
  input  wire logic                              ls_ready_i,
  output logic                                   sys_clk_tick_o,
  output logic                                   cpu_run_o,
  output logic                                   hs_osc_on_o,
  output logic                                   sub_clk_on_o,
  output logic                                   ls_rc_oscillator_on_o,
  output pwr_mode_pkg::mode_t                    mode_o,
  output logic                                   power_down_flag_o,
  output logic                                   wdt_timeout_flag_o,
  output logic                                   wdt_clear_o,
  output logic                                   pc_sp_reset_o,
  output logic                                   irq_vector_o,
  output logic                                   resume_o
);
  import pwr_mode_pkg::*;

  localparam int SYNC_W = PORTA_W + 2;

  // ==========================================
  // Helpers
  function automatic logic [5:0] div_mask(input logic [2:0] sel);
    logic [6:0] one_hot;
    one_hot = 7'h01 << sel;
    return 6'(one_hot - 7'h01);
  endfunction : div_mask

  function automatic logic is_low_power(input mode_t m);
    return (m == MODE_SLEEP) || (m == MODE_IDLE_LOWCLK_ONLY) ||
           (m == MODE_IDLE_BOTH_CLOCKS) || (m == MODE_IDLE_HIGHCLK_ONLY);
  endfunction : is_low_power

  // ==========================================
  // Pin synchronisers, dividers, stable flag
  logic [SYNC_W-1:0]  sync1_r;
  logic [SYNC_W-1:0]  sync2_r;
  logic [PORTA_W-1:0] pa_prev_r;
  logic [PORTA_W-1:0] pa_prev_nxt;
  logic [10:0]        ls_rc_oscillator_cnt_r;
  logic [10:0]        ls_rc_oscillator_cnt_nxt;
  logic               ls_tick_r;
  logic               ls_tick_nxt;
  logic [5:0]         fdiv_r;
  logic [5:0]         fdiv_nxt;
  logic               hs_on_d_r;
  logic               hs_stable_r;
  logic               hs_stable_nxt;
  logic [PORTA_W-1:0] pa_s;
  logic               hs_ready_s;
  logic               ls_ready_s;
  logic               pa_fall;
  logic               fast_tick;

  // Registers and state, declared ahead of use
  logic [7:0]         scc_r;
  logic [7:0]         scc_nxt;
  logic               hs_en_r;
  logic               hs_en_nxt;
  logic [7:0]         wake_en_r;
  logic [7:0]         wake_en_nxt;
  logic [7:0]         rdata_nxt;
  logic [2:0]         sel;
  mode_t              mode_r;
  mode_t              mode_nxt;
  logic               on_sub_r;
  logic               on_sub_nxt;
  logic [2:0]         sel_act_r;
  logic [2:0]         sel_act_nxt;
  logic [IRQ_W-1:0]   armed_r;
  logic [IRQ_W-1:0]   armed_nxt;
  logic               wake_wdt_r;
  logic               wake_wdt_nxt;
  logic               pdf_nxt;
  logic               to_nxt;
  logic               wdt_clr_nxt;
  logic               pcsp_nxt;
  logic               vec_nxt;
  logic               resume_nxt;
  logic               tick_nxt;
  logic               cpu_run_nxt;
  logic               hs_on_nxt;
  logic               sub_on_nxt;
  logic               ls_rc_oscillator_on_nxt;
  logic               run_mode;
  logic               wake_ev;

  assign pa_s       = sync2_r[SYNC_W-1:2];
  assign hs_ready_s = sync2_r[1];
  assign ls_ready_s = sync2_r[0];
  assign sel        = scc_r[SEL_MSB:SEL_LSB];
  // Divided high clock tick, ratio 2**sel_act
  assign fast_tick  = (fdiv_r & div_mask(sel_act_r)) == 6'h00; // RULE_20
  assign pa_fall    = |(pa_prev_r & ~pa_s & wake_en_r); // RULE_15

  always_comb begin : clk_comb
    pa_prev_nxt  = pa_s;
    fdiv_nxt     = fdiv_r + 6'h01;
    ls_rc_oscillator_cnt_nxt = ls_rc_oscillator_cnt_r;
    ls_tick_nxt  = 1'b0;
    if (ls_rc_oscillator_on_o) begin
      if (ls_rc_oscillator_cnt_r == 11'(LS_RC_OSCILLATOR_CYC - 1)) begin
        ls_rc_oscillator_cnt_nxt = 11'h000;
        ls_tick_nxt  = 1'b1;
      end else begin
        ls_rc_oscillator_cnt_nxt = ls_rc_oscillator_cnt_r + 11'h001;
      end
    end
    // Flag is low in the first cycle after enable, and while off
    hs_stable_nxt = hs_osc_on_o & hs_on_d_r & (hs_stable_r | hs_ready_s); // RULE_21
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r     <= '0;
      sync2_r     <= '0;
      pa_prev_r   <= '0;
      ls_rc_oscillator_cnt_r  <= 11'h000;
      ls_tick_r   <= 1'b0;
      fdiv_r      <= 6'h00;
      hs_on_d_r   <= 1'b0;
      hs_stable_r <= 1'b0;
    end else begin
      sync1_r     <= {porta_i, hs_ready_i, ls_ready_i};
      sync2_r     <= sync1_r;
      pa_prev_r   <= pa_prev_nxt;
      ls_rc_oscillator_cnt_r  <= ls_rc_oscillator_cnt_nxt;
      ls_tick_r   <= ls_tick_nxt;
      fdiv_r      <= fdiv_nxt;
      hs_on_d_r   <= hs_osc_on_o;
      hs_stable_r <= hs_stable_nxt;
    end
  end

  // ==========================================
  // Register port
  always_comb begin : reg_comb
    scc_nxt     = scc_r;
    hs_en_nxt   = hs_en_r;
    wake_en_nxt = wake_en_r;
    rdata_nxt   = 8'h00;
    if (wr_i) begin
      case (addr_i)
        ADDR_SCC:  scc_nxt     = wdata_i & 8'hE3;
        ADDR_HOSC: hs_en_nxt   = wdata_i[HS_EN_BIT];
        ADDR_WAKE: wake_en_nxt = wdata_i;
        default:   ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        ADDR_SCC:  rdata_nxt = scc_r;
        ADDR_HOSC: rdata_nxt = {6'h00, hs_stable_r, hs_en_r};
        ADDR_WAKE: rdata_nxt = wake_en_r;
        default: begin
          rdata_nxt[STAT_PDF_BIT] = power_down_flag_o;
          rdata_nxt[STAT_TO_BIT]  = wdt_timeout_flag_o;
          rdata_nxt[STAT_MODE_LSB +: 3] = mode_r;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scc_r     <= SCC_RST;
      hs_en_r   <= HS_EN_RST;
      wake_en_r <= WAKE_RST;
      rdata_o   <= 8'h00;
    end else begin
      scc_r     <= scc_nxt;
      hs_en_r   <= hs_en_nxt;
      wake_en_r <= wake_en_nxt;
      rdata_o   <= rdata_nxt;
    end
  end

  // ==========================================
  // Mode machine and status flags
  assign run_mode = (mode_r == MODE_FAST) || (mode_r == MODE_SLOW);
  // Requests already pending at halt are masked out of the wake term
  assign wake_ev  = pa_fall | (|(irq_req_i & armed_r)) | wdt_overflow_i; // RULE_12 RULE_18

  always_comb begin : fsm_comb
    mode_nxt     = mode_r;
    on_sub_nxt   = on_sub_r;
    sel_act_nxt  = sel_act_r;
    armed_nxt    = armed_r;
    wake_wdt_nxt = wake_wdt_r;
    pdf_nxt      = power_down_flag_o;
    to_nxt       = wdt_timeout_flag_o;
    wdt_clr_nxt  = 1'b0;
    pcsp_nxt     = 1'b0;
    vec_nxt      = 1'b0;
    resume_nxt   = 1'b0;
    if (clr_wdt_i) begin
      pdf_nxt = 1'b0; // RULE_13
    end
    case (mode_r)
      MODE_FAST, MODE_SLOW: begin
        if (halt_i) begin
          // Keep bits taken as they stand in this cycle
          case ({scc_r[HS_KEEP_BIT], scc_r[LS_KEEP_BIT]}) // RULE_24
            2'b00:   mode_nxt = MODE_SLEEP; // RULE_05
            2'b01:   mode_nxt = MODE_IDLE_LOWCLK_ONLY; // RULE_06
            2'b11:   mode_nxt = MODE_IDLE_BOTH_CLOCKS; // RULE_07
            default: mode_nxt = MODE_IDLE_HIGHCLK_ONLY; // RULE_08
          endcase
          armed_nxt   = ~irq_req_i; // RULE_18
          pdf_nxt     = 1'b1; // RULE_10
          to_nxt      = 1'b0; // RULE_10
          wdt_clr_nxt = 1'b1; // RULE_11
        end else if (mode_r == MODE_FAST) begin
          // Source and ratio change only on a tick of the old source
          if (fast_tick && sel == SEL_SUB && ls_ready_s) begin // RULE_01 RULE_03 RULE_23
            mode_nxt   = MODE_SLOW;
            on_sub_nxt = 1'b1;
          end else if (fast_tick && sel != SEL_SUB) begin // RULE_23
            sel_act_nxt = sel;
          end
        end else if (ls_tick_r && sel != SEL_SUB && hs_stable_r) begin // RULE_02 RULE_04
          mode_nxt    = MODE_FAST;
          on_sub_nxt  = 1'b0;
          sel_act_nxt = sel; // RULE_20
        end
      end
      MODE_SLEEP, MODE_IDLE_LOWCLK_ONLY, MODE_IDLE_BOTH_CLOCKS,
      MODE_IDLE_HIGHCLK_ONLY: begin
        if (wake_ev) begin // RULE_12
          mode_nxt     = MODE_WAKE;
          wake_wdt_nxt = wdt_overflow_i;
          pcsp_nxt     = wdt_overflow_i; // RULE_14
        end
      end
      MODE_WAKE: begin
        // Hold the CPU until the clock it ran on is stable again
        if (on_sub_r ? ls_ready_s : hs_stable_r) begin // RULE_19
          mode_nxt = on_sub_r ? MODE_SLOW : MODE_FAST;
          if (!wake_wdt_r) begin
            if ((|(irq_req_i & armed_r & irq_en_i)) && !stack_full_i) begin
              vec_nxt = 1'b1; // RULE_17
            end else begin
              // Request flag is untouched, so it stays pending
              resume_nxt = 1'b1; // RULE_15 RULE_16
            end
          end
        end
      end
      default: mode_nxt = MODE_FAST;
    endcase
    if (wdt_overflow_i) begin
      to_nxt = 1'b1; // RULE_14
    end
  end

  // Clock and oscillator requests follow the next mode
  always_comb begin : osc_comb
    cpu_run_nxt = (mode_nxt == MODE_FAST) || (mode_nxt == MODE_SLOW); // RULE_09
    tick_nxt    = run_mode && !halt_i && (on_sub_r ? ls_tick_r : fast_tick); // RULE_09
    ls_rc_oscillator_on_nxt = 1'b1;
    sub_on_nxt  = 1'b1;
    hs_on_nxt   = 1'b0;
    case (mode_nxt)
      MODE_FAST:              hs_on_nxt = 1'b1;
      MODE_SLOW:              hs_on_nxt = hs_en_r | (sel != SEL_SUB); // RULE_04
      MODE_SLEEP: begin
        sub_on_nxt  = 1'b0; // RULE_05
        ls_rc_oscillator_on_nxt = wdt_enable_i; // RULE_22
      end
      MODE_IDLE_LOWCLK_ONLY:  hs_on_nxt = 1'b0; // RULE_06
      MODE_IDLE_BOTH_CLOCKS:  hs_on_nxt = 1'b1; // RULE_07
      MODE_IDLE_HIGHCLK_ONLY: begin
        hs_on_nxt  = 1'b1; // RULE_08
        sub_on_nxt = 1'b0; // RULE_08
      end
      default:                hs_on_nxt = !on_sub_nxt | hs_en_r | (sel != SEL_SUB);
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_r             <= MODE_FAST;
      on_sub_r           <= 1'b0;
      sel_act_r          <= 3'h0;
      armed_r            <= '0;
      wake_wdt_r         <= 1'b0;
      power_down_flag_o  <= 1'b0;
      wdt_timeout_flag_o <= 1'b0;
      wdt_clear_o        <= 1'b0;
      pc_sp_reset_o      <= 1'b0;
      irq_vector_o       <= 1'b0;
      resume_o           <= 1'b0;
      sys_clk_tick_o     <= 1'b0;
      cpu_run_o          <= 1'b1;
      hs_osc_on_o        <= 1'b1;
      sub_clk_on_o       <= 1'b1;
      ls_rc_oscillator_on_o          <= 1'b1;
    end else begin
      mode_r             <= mode_nxt;
      on_sub_r           <= on_sub_nxt;
      sel_act_r          <= sel_act_nxt;
      armed_r            <= armed_nxt;
      wake_wdt_r         <= wake_wdt_nxt;
      power_down_flag_o  <= pdf_nxt;
      wdt_timeout_flag_o <= to_nxt;
      wdt_clear_o        <= wdt_clr_nxt;
      pc_sp_reset_o      <= pcsp_nxt;
      irq_vector_o       <= vec_nxt;
      resume_o           <= resume_nxt;
      sys_clk_tick_o     <= tick_nxt;
      cpu_run_o          <= cpu_run_nxt;
      hs_osc_on_o        <= hs_on_nxt;
      sub_clk_on_o       <= sub_on_nxt;
      ls_rc_oscillator_on_o          <= ls_rc_oscillator_on_nxt;
    end
  end

  assign mode_o = mode_r;

  // ==========================================
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  pdf_set_a: assert property (run_mode && halt_i |=> power_down_flag_o) // RULE_10
    else $error("power-down flag not set by halt");
  to_clear_a: assert property (run_mode && halt_i && !wdt_overflow_i |=> !wdt_timeout_flag_o) // RULE_10
    else $error("timeout flag not cleared by halt");
  wdt_clear_a: assert property (run_mode && halt_i |=> wdt_clear_o ##1 !wdt_clear_o) // RULE_11
    else $error("watchdog clear pulse missing");
  sleep_entry_a: assert property (run_mode && halt_i && scc_r[1:0] == 2'b00
      |=> mode_o == MODE_SLEEP && !hs_osc_on_o && !sub_clk_on_o) // RULE_05
    else $error("sleep entry wrong");
  idle_low_a: assert property (run_mode && halt_i && scc_r[1:0] == 2'b01
      |=> !hs_osc_on_o && sub_clk_on_o) // RULE_06
    else $error("low clock idle wrong");
  idle_both_a: assert property (run_mode && halt_i && scc_r[1:0] == 2'b11
      |=> hs_osc_on_o && sub_clk_on_o && !cpu_run_o) // RULE_07
    else $error("both clock idle wrong");
  idle_high_a: assert property (run_mode && halt_i && scc_r[1:0] == 2'b10
      |=> hs_osc_on_o && !sub_clk_on_o) // RULE_08
    else $error("high clock idle wrong");
  lp_stopped_a: assert property (is_low_power(mode_o) |-> !sys_clk_tick_o && !cpu_run_o) // RULE_09
    else $error("clock runs in low power");
  pdf_clear_a: assert property (clr_wdt_i && !(run_mode && halt_i) |=> !power_down_flag_o) // RULE_13
    else $error("power-down flag not cleared");
  wdt_wake_a: assert property (is_low_power(mode_o) && wdt_overflow_i
      |=> wdt_timeout_flag_o && pc_sp_reset_o && mode_o == MODE_WAKE) // RULE_14
    else $error("watchdog wake wrong");
  slow_entry_a: assert property (mode_o == MODE_FAST && !ls_ready_s |=> mode_o != MODE_SLOW) // RULE_03
    else $error("slow entered before stable");
  wake_hold_a: assert property (mode_o == MODE_WAKE && !on_sub_r && !hs_stable_r
      |=> mode_o == MODE_WAKE) // RULE_19
    else $error("resumed before oscillator stable");
  ls_rc_oscillator_sleep_a: assert property (mode_o == MODE_SLEEP |-> ls_rc_oscillator_on_o == $past(wdt_enable_i)) // RULE_22
    else $error("slow RC wrong in sleep");

  sleep_c: cover property (mode_o == MODE_SLEEP ##[1:1000] mode_o == MODE_WAKE);
  slow_c: cover property (mode_o == MODE_FAST ##1 mode_o == MODE_SLOW);
  vector_c: cover property (irq_vector_o);
  resume_c: cover property (resume_o && on_sub_r);
endmodule : power_mode_wakeup_control

// File: tb/cpu_model.sv
// CPU core model that issues the halt instruction for the bench
`timescale 1ns/1ps
module cpu_model (
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic halt_req_i,
  input  wire logic cpu_run_i,
  output logic      halt_o
);
  // ==========================================
  // Halt issue
  // A stopped core cannot execute, so no halt while the run enable is low
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      halt_o <= 1'b0;
    end else begin
      halt_o <= halt_req_i && cpu_run_i && !halt_o;
    end
  end
endmodule : cpu_model

// File: tb/testbench.sv
// Self-checking bench for the power mode and wake-up controller
`timescale 1ns/1ps
module testbench;
  import pwr_mode_pkg::*;
  // ==========================================
  // Signals
  localparam int         LCYC = 8;
  // Keep codes per pass, two bits each from the bottom: 00, 01, 11, 10
  localparam logic [7:0] KEEPS = 8'hB4;
  logic                  mclk_i = 1'b0;
  logic                  rst_b_i = 1'b0;
  logic [1:0]            addr_i = 2'h0;
  logic [7:0]            wdata_i = 8'h00;
  logic                  wr_i = 1'b0;
  logic                  rd_i = 1'b0;
  logic                  halt_req = 1'b0;
  logic                  halt_i;
  logic                  clr_wdt_i = 1'b0;
  logic                  wdt_enable_i = 1'b0;
  logic                  wdt_overflow_i = 1'b0;
  logic [7:0]            irq_req_i = 8'h00;
  logic [7:0]            irq_en_i = 8'h00;
  logic                  stack_full_i = 1'b0;
  logic [7:0]            porta_i = 8'hFF;
  logic                  hs_ready_i = 1'b0;
  logic                  ls_ready_i = 1'b1;
  logic [3:0]            hs_sr = 4'h0;
  logic [7:0]            rdata_o;
  logic                  tick, run, hs_on, sub_on, ls_rc_oscillator_on, power_down_flag, tof, wclr, pcsp, vec, res;
  mode_t                 mode_o;
  logic [7:0]            seed = 8'h29;
  logic [7:0]            d, pre;
  logic [1:0]            keep;
  logic                  sw, v, r, p;
  int                    n_mismatch = 0;
  int                    cmp_count = 0;
  int                    i, k, n, per, sel;

  always #10 mclk_i = ~mclk_i;

  // Oscillator ready follows its enable after a start-up delay and drops when off
  always @(posedge mclk_i) begin
    hs_sr      <= {hs_sr[2:0], hs_on};
    hs_ready_i <= &hs_sr;
  end

  power_mode_wakeup_control #(.IRQ_W(8), .LS_RC_OSCILLATOR_CYC(LCYC)) dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .halt_i(halt_i), .clr_wdt_i(clr_wdt_i),
    .wdt_enable_i(wdt_enable_i), .wdt_overflow_i(wdt_overflow_i), .irq_req_i(irq_req_i),
    .irq_en_i(irq_en_i), .stack_full_i(stack_full_i), .porta_i(porta_i),
    .hs_ready_i(hs_ready_i), .ls_ready_i(ls_ready_i), .sys_clk_tick_o(tick),
    .cpu_run_o(run), .hs_osc_on_o(hs_on), .sub_clk_on_o(sub_on), .ls_rc_oscillator_on_o(ls_rc_oscillator_on),
    .mode_o(mode_o), .power_down_flag_o(power_down_flag), .wdt_timeout_flag_o(tof), .wdt_clear_o(wclr),
    .pc_sp_reset_o(pcsp), .irq_vector_o(vec), .resume_o(res));

  cpu_model cpu (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .halt_req_i(halt_req), .cpu_run_i(run),
    .halt_o(halt_i));

  // ==========================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic mode_t exp_mode(input logic [1:0] kb);
    case (kb)
      2'b00:   return MODE_SLEEP;
      2'b01:   return MODE_IDLE_LOWCLK_ONLY;
      2'b11:   return MODE_IDLE_BOTH_CLOCKS;
      default: return MODE_IDLE_HIGHCLK_ONLY;
    endcase
  endfunction : exp_mode

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [1:0] a, input logic [7:0] dv);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= dv;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] dv);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1 dv = rdata_o;
  endtask : rd

  task automatic cyc(input int c);
    repeat (c) @(posedge mclk_i);
    #1;
  endtask : cyc

  // Period between two ticks; the first two gaps are dropped as they may straddle a change
  task automatic tick_gap(output int pv);
    int m;
    m = 0;
    repeat (3) begin
      m = 0;
      do begin cyc(1); m++; end while (tick !== 1'b1 && m < 300);
    end
    pv = m;
  endtask : tick_gap

  initial begin
    #400000;
    n_mismatch++;
    stop_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    cyc(2);
    rst_b_i <= 1'b1;
    cyc(10);
    check("mode rst", 8'(mode_o), 8'(MODE_FAST));
    rd(ADDR_SCC, d);  check("scc rst", d, SCC_RST);
    rd(ADDR_HOSC, d); check("hosc rst", d, 8'h03);
    rd(ADDR_WAKE, d); check("wake rst", d, WAKE_RST);
    rd(ADDR_STAT, d); check("stat rst", d, 8'h00);
    // Slow switch waits for the sub oscillator
    ls_ready_i <= 1'b0;
    wr(ADDR_SCC, 8'hE0);
    cyc(40);
    check("fast held", 8'(mode_o), 8'(MODE_FAST));
    ls_ready_i <= 1'b1;
    n = 0;
    while (mode_o !== MODE_SLOW && n < 200) begin cyc(1); n++; end
    check("slow", 8'(mode_o), 8'(MODE_SLOW));
    tick_gap(per); check("slow gap", 8'(per), 8'(LCYC));
    wr(ADDR_HOSC, 8'h00);
    cyc(10);
    wr(ADDR_HOSC, 8'h01);
    rd(ADDR_HOSC, d); check("stable clr", d, 8'h01);
    seed = lfsr(seed);
    sel = seed % 7;
    wr(ADDR_SCC, 8'(sel << SEL_LSB));
    n = 0;
    while (mode_o !== MODE_FAST && n < 200) begin cyc(1); n++; end
    check("fast", 8'(mode_o), 8'(MODE_FAST));
    check("hs ready", 8'(hs_ready_i), 8'h01);
    for (i = 0; i < 3; i++) begin
      tick_gap(per); check("fast gap", 8'(per), 8'(1 << sel));
      sel = (i == 0) ? 6 : (i == 1) ? 0 : 3;
      wr(ADDR_SCC, 8'(sel << SEL_LSB));
    end
    // Halt in every keep code, woken by interrupt, port pin or watchdog overflow
    for (i = 0; i < 5; i++) begin
      keep = KEEPS[2 * (i % 4) +: 2];
      seed = lfsr(seed);
      k = seed[2:0];
      pre = 8'h01 << (k ^ 4);
      // Last pass halts from SLOW with the slow RC kept for the watchdog
      wdt_enable_i <= (i == 4) ? 1'b1 : seed[3];
      irq_req_i <= (i == 1) ? pre : 8'h00;
      wr(ADDR_SCC, {(i == 4) ? SEL_SUB : 3'h0, 3'h0, keep});
      wr(ADDR_WAKE, 8'h01 << k);
      @(posedge mclk_i) halt_req <= 1'b1;
      @(posedge mclk_i) halt_req <= 1'b0;
      n = 0;
      do begin cyc(1); n++; end while (run !== 1'b0 && n < 10);
      check("lp mode", 8'(mode_o), 8'(exp_mode(keep)));
      check("pdf", 8'(power_down_flag), 8'h01);
      check("to clr", 8'(tof), 8'h00);
      check("wclr", 8'(wclr), 8'h01);
      check("run", 8'(run), 8'h00);
      check("hs on", 8'(hs_on), 8'(keep[1]));
      check("sub on", 8'(sub_on), 8'(keep[0]));
      if (keep == 2'b00) check("ls_rc_oscillator", 8'(ls_rc_oscillator_on), 8'(wdt_enable_i));
      cyc(1);
      check("wclr end", 8'(wclr), 8'h00);
      @(posedge mclk_i);
      case (i % 4)
        0: begin irq_en_i <= 8'hFF; irq_req_i <= 8'h01 << k; end
        1: begin
          cyc(20);
          check("pend no wake", 8'(mode_o), 8'(exp_mode(keep)));
          irq_en_i <= 8'hFF;
          stack_full_i <= 1'b1;
          irq_req_i <= pre | (8'h01 << k);
        end
        2: begin
          porta_i <= ~(8'h01 << (k ^ 1));
          cyc(10);
          check("pin off", 8'(mode_o), 8'(exp_mode(keep)));
          porta_i <= ~(8'h01 << k);
        end
        // Lowered by the watch loop, so its one-cycle wake pulse is seen
        default: wdt_overflow_i <= 1'b1;
      endcase
      {sw, v, r, p} = 4'h0;
      n = 0;
      while (n < 400) begin
        cyc(1);
        wdt_overflow_i <= 1'b0;
        sw |= (mode_o === MODE_WAKE);
        v |= (vec === 1'b1);
        r |= (res === 1'b1);
        p |= (pcsp === 1'b1);
        n = (run === 1'b1) ? n + 200 : n + 1;
      end
      check("wake seen", 8'(sw), 8'h01);
      check("vector", 8'(v), 8'(i % 4 == 0));
      check("resume", 8'(r), 8'(i % 4 == 1 || i % 4 == 2));
      check("pc sp", 8'(p), 8'(i % 4 == 3));
      check("back run", 8'(mode_o), 8'((i == 4) ? MODE_SLOW : MODE_FAST));
      // High clock restarts behind a return to SLOW, so give it time
      cyc(10);
      rd(ADDR_HOSC, d); check("stable", d[1], 1'b1);
      rd(ADDR_STAT, d); check("flags", d[1:0], {1'b0, i % 4 == 3} << 1 | 2'b01);
      irq_req_i <= 8'h00;
      porta_i <= 8'hFF;
      stack_full_i <= 1'b0;
      @(posedge mclk_i) clr_wdt_i <= 1'b1;
      @(posedge mclk_i) clr_wdt_i <= 1'b0;
      rd(ADDR_STAT, d); check("pdf clr", d[0], 1'b0);
    end
    stop_test();
  end
endmodule : testbench
